/* src/ssde_map.vh */
// Constants for the sense data encoder: sense keys, codes, qualifiers, byte layout.
// Assumes inclusion by the encoder modules only.
`ifndef SSDE_MAP_VH
`define SSDE_MAP_VH
`define SSDE_SK_NONE      4'h0
`define SSDE_SK_ILLEGAL   4'h5
`define SSDE_SK_UNIT_ATTN 4'h6
`define SSDE_SK_DENIED    4'h7
`define SSDE_SK_ABORTED   4'hb
`define SSDE_SK_MISCMP    4'he
`define SSDE_ASC_NONE     8'h00
`define SSDE_ASC_MWRITE   8'h0c
`define SSDE_ASC_IU       8'h0e
`define SSDE_ASC_E2E      8'h10
`define SSDE_ASC_MISCMP   8'h1d
`define SSDE_ASC_DENIED   8'h20
`define SSDE_ASC_CHANGED  8'h3f
`define SSDE_ASC_INTERNAL 8'h44
`define SSDE_ASC_CRC      8'h47
`define SSDE_ASC_DPHASE   8'h4b
`define SSDE_ASC_OVERLAP  8'h4e
`define SSDE_ASC_OOB      8'h4f
`define SSDE_Q_00         8'h00
`define SSDE_Q_01         8'h01
`define SSDE_Q_02         8'h02
`define SSDE_Q_03         8'h03
`define SSDE_Q_04         8'h04
`define SSDE_Q_05         8'h05
`define SSDE_Q_06         8'h06
`define SSDE_Q_0E         8'h0e
`define SSDE_Q_0F         8'h0f
`define SSDE_Q_FF         8'hff
`define SSDE_NUM_ERR      27
`define SSDE_UNIT_BYTE    8'h00
`define SSDE_SENSE_SPECIFIC_VALID_BIT     7
`define SSDE_CD_BIT       6
`define SSDE_BPV_BIT      3
`define SSDE_ST_IDLE      1'b0
`define SSDE_ST_HOLD      1'b1
`endif

/* src/ssde_prio.v */
// Fixed-priority selector over the error request vector; lowest index wins.
// Assumes a vector of level requests, purely combinational.
`timescale 1ns/10ps
`include "ssde_map.vh"
module ssde_prio
(
   reqVec,
   anyReq,
   winIdx
);
   input  wire [26:0] reqVec;
   output reg         anyReq;
   output reg  [4:0]  winIdx;
   integer i;
   always @*
   begin
      anyReq = 1'b0;
      winIdx = 5'h00;
      for (i = `SSDE_NUM_ERR - 1; i >= 0; i = i - 1)
      begin
         if (reqVec[i])
         begin
            anyReq = 1'b1;
            winIdx = i[4:0];
         end
      end
   end
endmodule

/* src/ssde_field_ptr.v */
// Builds sense byte 15 and field pointer bytes 16-17 for an illegal request.
// Assumes the pointer inputs are stable while the selected key is presented.
`timescale 1ns/10ps
`include "ssde_map.vh"
module ssde_field_ptr
(
   senseKey,
   cmdOrData,
   bitPtrValid,
   bitPtr,
   fieldPtr,
   byte15,
   byte16,
   byte17
);
   input  wire [3:0]  senseKey;
   input  wire        cmdOrData;
   input  wire        bitPtrValid;
   input  wire [2:0]  bitPtr;
   input  wire [15:0] fieldPtr;
   output reg  [7:0]  byte15;
   output reg  [7:0]  byte16;
   output reg  [7:0]  byte17;
   always @*
   begin
      byte15 = 8'h00;
      byte16 = 8'h00;
      byte17 = 8'h00;
      // Only the illegal-request layout is built here; other keys leave the bytes invalid.
      if (senseKey == `SSDE_SK_ILLEGAL)
      begin
         byte15[`SSDE_SENSE_SPECIFIC_VALID_BIT] = 1'b1;
         byte15[`SSDE_CD_BIT]   = cmdOrData;
         byte15[`SSDE_BPV_BIT]  = bitPtrValid;
         byte15[2:0]            = bitPtrValid ? bitPtr : 3'h0;
         byte16                 = fieldPtr[15:8];
         byte17                 = fieldPtr[7:0];
      end
   end
endmodule

/* src/ssde_encoder.v */
// Sense data encoder top: latches error events and presents sense key, code, qualifier
// and bytes 14-17 to the host interface until the sense data is taken.
// Assumes inputs synchronous to core_clk; errValid is a one-cycle strobe per command.
`timescale 1ns/10ps
`include "ssde_map.vh"
module ssde_encoder
(
   core_clk,
   resetn,
   errValid,
   errVec,
   illegalReq,
   cmdOrData,
   bitPtrValid,
   bitPtr,
   fieldPtr,
   senseTaken,
   senseReady_ff,
   senseKey_ff,
   addSenseCode_ff,
   addSenseQual_ff,
   replaceableUnitByte_ff,
   senseSpecific15_ff,
   senseSpecific16_ff,
   senseSpecific17_ff
);
   input  wire        core_clk;
   input  wire        resetn;
   input  wire        errValid;
   input  wire [26:0] errVec;
   input  wire        illegalReq;
   input  wire        cmdOrData;
   input  wire        bitPtrValid;
   input  wire [2:0]  bitPtr;
   input  wire [15:0] fieldPtr;
   input  wire        senseTaken;
   output reg         senseReady_ff;
   output reg  [3:0]  senseKey_ff;
   output reg  [7:0]  addSenseCode_ff;
   output reg  [7:0]  addSenseQual_ff;
   output reg  [7:0]  replaceableUnitByte_ff;
   output reg  [7:0]  senseSpecific15_ff;
   output reg  [7:0]  senseSpecific16_ff;
   output reg  [7:0]  senseSpecific17_ff;

   wire        anyErr;
   wire [4:0]  winIdx;
   wire [7:0]  ptrB15;
   wire [7:0]  ptrB16;
   wire [7:0]  ptrB17;
   reg  [3:0]  selKey;
   reg  [7:0]  selAsc;
   reg  [7:0]  selAscq;
   reg         state_ff;
   reg         nxt_state;

   // Index of errVec bit to its sense triple; lower index means higher priority.
   function [19:0] ssde_lookup;
      input [4:0] idx;
      begin
         case (idx)
            5'h00: ssde_lookup = {`SSDE_SK_UNIT_ATTN, `SSDE_ASC_CHANGED, `SSDE_Q_05};
            5'h01: ssde_lookup = {`SSDE_SK_DENIED, `SSDE_ASC_DENIED, `SSDE_Q_02};
            5'h02: ssde_lookup = {`SSDE_SK_ABORTED, `SSDE_ASC_MWRITE, `SSDE_Q_0E};
            5'h03: ssde_lookup = {`SSDE_SK_ABORTED, `SSDE_ASC_IU, `SSDE_Q_01};
            5'h04: ssde_lookup = {`SSDE_SK_ABORTED, `SSDE_ASC_IU, `SSDE_Q_02};
            5'h05: ssde_lookup = {`SSDE_SK_ABORTED, `SSDE_ASC_E2E, `SSDE_Q_01};
            5'h06: ssde_lookup = {`SSDE_SK_ABORTED, `SSDE_ASC_E2E, `SSDE_Q_02};
            5'h07: ssde_lookup = {`SSDE_SK_ABORTED, `SSDE_ASC_E2E, `SSDE_Q_03};
            5'h08: ssde_lookup = {`SSDE_SK_ABORTED, `SSDE_ASC_E2E, `SSDE_Q_01};
            5'h09: ssde_lookup = {`SSDE_SK_ABORTED, `SSDE_ASC_E2E, `SSDE_Q_02};
            5'h0a: ssde_lookup = {`SSDE_SK_ABORTED, `SSDE_ASC_E2E, `SSDE_Q_03};
            5'h0b: ssde_lookup = {`SSDE_SK_ABORTED, `SSDE_ASC_INTERNAL, `SSDE_Q_00};
            5'h0c: ssde_lookup = {`SSDE_SK_ABORTED, `SSDE_ASC_INTERNAL, `SSDE_Q_00};
            5'h0d: ssde_lookup = {`SSDE_SK_ABORTED, `SSDE_ASC_INTERNAL, `SSDE_Q_00};
            5'h0e: ssde_lookup = {`SSDE_SK_ABORTED, `SSDE_ASC_CRC, `SSDE_Q_01};
            5'h0f: ssde_lookup = {`SSDE_SK_ABORTED, `SSDE_ASC_DPHASE, `SSDE_Q_00};
            5'h10: ssde_lookup = {`SSDE_SK_ABORTED, `SSDE_ASC_DPHASE, `SSDE_Q_02};
            5'h11: ssde_lookup = {`SSDE_SK_ABORTED, `SSDE_ASC_DPHASE, `SSDE_Q_03};
            5'h12: ssde_lookup = {`SSDE_SK_ABORTED, `SSDE_ASC_DPHASE, `SSDE_Q_04};
            5'h13: ssde_lookup = {`SSDE_SK_ABORTED, `SSDE_ASC_DPHASE, `SSDE_Q_05};
            5'h14: ssde_lookup = {`SSDE_SK_ABORTED, `SSDE_ASC_DPHASE, `SSDE_Q_06};
            5'h15: ssde_lookup = {`SSDE_SK_ABORTED, `SSDE_ASC_DPHASE, `SSDE_Q_FF};
            5'h16: ssde_lookup = {`SSDE_SK_ABORTED, `SSDE_ASC_OVERLAP, `SSDE_Q_00};
            5'h17: ssde_lookup = {`SSDE_SK_ABORTED, `SSDE_ASC_OOB, `SSDE_Q_00};
            5'h18: ssde_lookup = {`SSDE_SK_ABORTED, `SSDE_ASC_CHANGED, `SSDE_Q_0F};
            5'h19: ssde_lookup = {`SSDE_SK_MISCMP, `SSDE_ASC_MISCMP, `SSDE_Q_00};
            default: ssde_lookup = {`SSDE_SK_NONE, `SSDE_ASC_NONE, `SSDE_Q_00};
         endcase
      end
   endfunction

   ssde_prio u_prio
   (
      .reqVec (errVec),
      .anyReq (anyErr),
      .winIdx (winIdx)
   );

   // An illegal request outranks every listed error, since it stops the command first.
   always @*
   begin
      if (illegalReq)
      begin
         selKey  = `SSDE_SK_ILLEGAL;
         selAsc  = `SSDE_ASC_NONE;
         selAscq = `SSDE_Q_00;
      end
      else
      begin
         {selKey, selAsc, selAscq} = ssde_lookup(winIdx);
      end
   end

   ssde_field_ptr u_fptr
   (
      .senseKey    (selKey),
      .cmdOrData   (cmdOrData),
      .bitPtrValid (bitPtrValid),
      .bitPtr      (bitPtr),
      .fieldPtr    (fieldPtr),
      .byte15      (ptrB15),
      .byte16      (ptrB16),
      .byte17      (ptrB17)
   );

   // A new strobe while sense is held is dropped: first error of a command is reported.
   always @*
   begin
      nxt_state = state_ff;
      case (state_ff)
         `SSDE_ST_IDLE:
         begin
            if (errValid && (anyErr || illegalReq))
            begin
               nxt_state = `SSDE_ST_HOLD;
            end
         end
         default:
         begin
            if (senseTaken)
            begin
               nxt_state = `SSDE_ST_IDLE;
            end
         end
      endcase
   end

   always @(posedge core_clk or negedge resetn)
   begin
      if (!resetn)
      begin
         state_ff               <= `SSDE_ST_IDLE;
         senseReady_ff          <= 1'b0;
         senseKey_ff            <= `SSDE_SK_NONE;
         addSenseCode_ff        <= `SSDE_ASC_NONE;
         addSenseQual_ff        <= `SSDE_Q_00;
         replaceableUnitByte_ff <= `SSDE_UNIT_BYTE;
         senseSpecific15_ff     <= 8'h00;
         senseSpecific16_ff     <= 8'h00;
         senseSpecific17_ff     <= 8'h00;
      end
      else
      begin
         state_ff               <= nxt_state;
         senseReady_ff          <= (nxt_state == `SSDE_ST_HOLD);
         replaceableUnitByte_ff <= `SSDE_UNIT_BYTE;
         if (state_ff == `SSDE_ST_IDLE && nxt_state == `SSDE_ST_HOLD)
         begin
            senseKey_ff        <= selKey;
            addSenseCode_ff    <= selAsc;
            addSenseQual_ff    <= selAscq;
            senseSpecific15_ff <= ptrB15;
            senseSpecific16_ff <= ptrB16;
            senseSpecific17_ff <= ptrB17;
         end
      end
   end
endmodule

/* tb/ssde_encoder_chk.sv */
// Port-level assertions for the sense data encoder.
// Assumes it is bound to ssde_encoder and sees a single clock domain.
`timescale 1ns/10ps
module ssde_encoder_chk
(
   input wire logic        core_clk,
   input wire logic        resetn,
   input wire logic        errValid,
   input wire logic [26:0] errVec,
   input wire logic        illegalReq,
   input wire logic        cmdOrData,
   input wire logic        bitPtrValid,
   input wire logic [2:0]  bitPtr,
   input wire logic [15:0] fieldPtr,
   input wire logic        senseTaken,
   input wire logic        senseReady_ff,
   input wire logic [3:0]  senseKey_ff,
   input wire logic [7:0]  addSenseCode_ff,
   input wire logic [7:0]  addSenseQual_ff,
   input wire logic [7:0]  replaceableUnitByte_ff,
   input wire logic [7:0]  senseSpecific15_ff,
   input wire logic [7:0]  senseSpecific16_ff,
   input wire logic [7:0]  senseSpecific17_ff
);
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!resetn);
   sequence s_take;
      errValid && !senseReady_ff && (|errVec || illegalReq);
   endsequence
   sequence s_ill;
      s_take ##0 illegalReq;
   endsequence
   property p_unit; replaceableUnitByte_ff == 8'h00; endproperty
   a_unit: assert property (p_unit) else $error("unit byte not zero");
   property p_ikey; s_ill |=> senseKey_ff == 4'h5 && addSenseCode_ff == 8'h00; endproperty
   a_ikey: assert property (p_ikey) else $error("illegal key wrong");
   property p_zero; senseReady_ff && senseKey_ff != 4'h5 |-> senseSpecific15_ff == 8'h00; endproperty
   a_zero: assert property (p_zero) else $error("byte 15 not zero");
   property p_cd; s_ill |=> senseSpecific15_ff[7:6] == {1'b1, $past(cmdOrData)}; endproperty
   a_cd: assert property (p_cd) else $error("byte 15 flags wrong");
   property p_bp; s_ill |=> senseSpecific15_ff[3:0] == ($past(bitPtrValid) ? {1'b1, $past(bitPtr)} : 4'h0); endproperty
   a_bp: assert property (p_bp) else $error("bit pointer wrong");
   property p_fp; s_ill |=> {senseSpecific16_ff, senseSpecific17_ff} == $past(fieldPtr); endproperty
   a_fp: assert property (p_fp) else $error("field pointer wrong");
   property p_id; s_take ##0 (!illegalReq && errVec[0]) |=> senseKey_ff == 4'h6 && addSenseQual_ff == 8'h05; endproperty
   a_id: assert property (p_id) else $error("id change code wrong");
   property p_mis; s_take ##0 (!illegalReq && errVec[25:0] == 26'h2000000) |=> addSenseCode_ff == 8'h1d; endproperty
   a_mis: assert property (p_mis) else $error("miscompare code wrong");
   property p_hold; senseReady_ff && !senseTaken |=> senseReady_ff && $stable(addSenseQual_ff); endproperty
   a_hold: assert property (p_hold) else $error("held sense changed");
endmodule
bind ssde_encoder ssde_encoder_chk chk (.*);

/* tb/ssde_host_model.sv */
// Host partner that reads held sense data and then frees it.
// Assumes the encoder samples senseTaken on core_clk rising edges.
`timescale 1ns/10ps
module ssde_host_model
(
   input  wire logic       core_clk,
   input  wire logic       resetn,
   input  wire logic       senseReady_ff,
   input  wire logic [3:0] waitCycles,
   output logic            senseTaken
);
   logic [3:0] waitCnt_ff;
   // A slow read keeps the hold open so later errors can be shown to be dropped.
   always @(posedge core_clk or negedge resetn)
   begin
      if (!resetn || senseTaken)
      begin
         senseTaken <= 1'b0;
         waitCnt_ff <= 4'h0;
      end
      else if (senseReady_ff && waitCnt_ff == waitCycles)
         senseTaken <= 1'b1;
      else if (senseReady_ff)
         waitCnt_ff <= waitCnt_ff + 4'h1;
   end
endmodule

/* tb/testbench.sv */
// Self-checking bench for the sense data encoder.
// Assumes the host model frees every sense hold.
`timescale 1ns/10ps
module testbench;
   logic        core_clk, resetn, errValid, illegalReq, cmdOrData, bitPtrValid, senseTaken, senseReady_ff;
   logic [26:0] errVec;
   logic [2:0]  bitPtr;
   logic [3:0]  senseKey_ff, waitCycles;
   logic [15:0] fieldPtr;
   logic [7:0]  addSenseCode_ff, addSenseQual_ff, replaceableUnitByte_ff;
   logic [7:0]  senseSpecific15_ff, senseSpecific16_ff, senseSpecific17_ff;
   int          miscompares, cmp_count;
   localparam logic [19:0] CODES [26] = '{20'h63f05, 20'h72002, 20'hb0c0e, 20'hb0e01, 20'hb0e02, 20'hb1001,
      20'hb1002, 20'hb1003, 20'hb1001, 20'hb1002, 20'hb1003, 20'hb4400, 20'hb4400, 20'hb4400, 20'hb4701,
      20'hb4b00, 20'hb4b02, 20'hb4b03, 20'hb4b04, 20'hb4b05, 20'hb4b06, 20'hb4bff, 20'hb4e00, 20'hb4f00,
      20'hb3f0f, 20'he1d00};
   ssde_encoder dut (.*);
   ssde_host_model host (.core_clk(core_clk), .resetn(resetn), .senseReady_ff(senseReady_ff),
      .waitCycles(waitCycles), .senseTaken(senseTaken));
   initial
   begin
      core_clk = 1'b0;
      forever #12.5 core_clk = ~core_clk;
   end
   task automatic conclude();
      $display("compares %0d miscompares %0d", cmp_count, miscompares);
      if (miscompares == 0 && cmp_count > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      cmp_count++;
      if (got !== exp)
      begin
         miscompares++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic send(input logic [26:0] v, input logic ill, input logic [4:0] ptr, input logic [15:0] fp,
                       input logic [3:0] w);
      @(posedge core_clk);
      errValid <= 1'b1;
      errVec <= v;
      illegalReq <= ill;
      {cmdOrData, bitPtrValid, bitPtr} <= ptr;
      fieldPtr <= fp;
      waitCycles <= w;
      @(posedge core_clk);
      errValid <= 1'b0;
      #1;
   endtask
   task automatic idle();
      int n;
      n = 0;
      while (senseReady_ff !== 1'b0 && n < 40)
      begin
         @(posedge core_clk);
         #1;
         n++;
      end
      if (n == 40)
      begin
         miscompares++;
         conclude();
      end
   endtask
   task automatic t_codes();
      for (int i = 0; i < 26; i++)
      begin
         send(27'h1 << i, 1'b0, 5'h0, 16'h0, i[3:0]);
         chk({senseKey_ff, addSenseCode_ff, addSenseQual_ff}, CODES[i]);
         chk(replaceableUnitByte_ff, 8'h00);
         chk({senseSpecific15_ff, senseSpecific16_ff, senseSpecific17_ff}, 24'h0);
         idle();
      end
      $display("t_codes done");
   endtask
   task automatic t_illegal();
      send(27'h7ffffff, 1'b1, 5'b11101, 16'h0102, 4'h2);
      chk({senseKey_ff, addSenseCode_ff, addSenseQual_ff}, 20'h50000);
      chk({senseSpecific15_ff, senseSpecific16_ff, senseSpecific17_ff}, 24'hcd0102);
      idle();
      send(27'h0, 1'b1, 5'b00111, 16'hfffe, 4'h0);
      chk({senseSpecific15_ff, senseSpecific16_ff, senseSpecific17_ff}, 24'h80fffe);
      idle();
      $display("t_illegal done");
   endtask
   task automatic t_prio();
      send(27'h2004000, 1'b0, 5'h0, 16'h0, 4'h1);
      chk({senseKey_ff, addSenseCode_ff, addSenseQual_ff}, 20'hb4701);
      idle();
      send(27'h18, 1'b0, 5'h0, 16'h0, 4'h0);
      chk({senseKey_ff, addSenseCode_ff, addSenseQual_ff}, 20'hb0e01);
      idle();
      // The spare class still opens a hold, but carries an empty triple and no pointer bytes.
      send(27'h4000000, 1'b0, 5'h1f, 16'habcd, 4'h0);
      chk(senseReady_ff, 1'b1);
      chk({senseKey_ff, addSenseCode_ff, addSenseQual_ff}, 20'h00000);
      chk({senseSpecific15_ff, senseSpecific16_ff, senseSpecific17_ff}, 24'h0);
      idle();
      $display("t_prio done");
   endtask
   task automatic t_refuse();
      send(27'h1, 1'b0, 5'h0, 16'h0, 4'h8);
      send(27'h2000000, 1'b0, 5'h0, 16'h0, 4'h8);
      chk(senseReady_ff, 1'b1);
      chk({senseKey_ff, addSenseCode_ff, addSenseQual_ff}, 20'h63f05);
      idle();
      send(27'h0, 1'b0, 5'h0, 16'h0, 4'h0);
      chk(senseReady_ff, 1'b0);
      $display("t_refuse done");
   endtask
   initial
   begin
      resetn = 1'b0;
      {errValid, errVec, illegalReq, cmdOrData, bitPtrValid, bitPtr, fieldPtr, waitCycles} = '0;
      miscompares = 0;
      cmp_count = 0;
      repeat (16) @(posedge core_clk);
      resetn <= 1'b1;
      t_codes();
      t_illegal();
      t_prio();
      t_refuse();
      conclude();
   end
endmodule
